// ### rtl/swdt_pkg.sv
// Constants, field layout and state type of the software watchdog timer
//
// Behaviour
// - Control readable always; writes ignored while interrupt pending
// - Counter idle after reset until enabled
// - Control bit 7 enables counting
// - Bit 6: soft reset, else interrupt at level
// - Bit 5 divides watchdog clock by 8192
// - Bits 4:3 with prescale pick eight periods
// - Reset selects shortest timeout period
// - Further unacknowledged period asserts transfer acknowledge
// - Sticky terminate flag, cleared by writing one
// - Vector register returned during interrupt acknowledge
// - Vector write-only, resets to 0f
// - Other accesses allowed between both service writes
// - Service writes never negate pending interrupt
// - Service register 8-bit, write-only, no storage
// - Completed service sequence restarts the counter
// - Reset timeout pulses soft reset and cause

package swdt_pkg;

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 2'h0;
  localparam logic [ADDR_W-1:0] VECTOR_ADDR = 2'h1;
  localparam logic [ADDR_W-1:0] SERVICE_ADDR = 2'h2;

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int ENABLE_BIT = 7;
  localparam int ACTION_BIT = 6;
  localparam int PRESCALE_BIT = 5;
  localparam int PERIOD_HI = 4;
  localparam int PERIOD_LO = 3;
  localparam int TERM_EN_BIT = 2;
  localparam int TERM_FLAG_BIT = 1;

  // ----------------------------------------------------------------
  // Reset values and service keys
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] VECTOR_RESET = 8'h0f;
  localparam logic [DATA_W-1:0] SERVICE_KEY1 = 8'h55;
  localparam logic [DATA_W-1:0] SERVICE_KEY2 = 8'haa;
  localparam logic [1:0] PERIOD_RESET = 2'h0;
  localparam int LEVEL_W = 3;

  // ----------------------------------------------------------------
  // Timeout counts in bus clocks
  // ----------------------------------------------------------------
  localparam int CNT_W = 28;
  localparam int unsigned PERIOD_SHORT = 512;
  localparam int unsigned PRESCALE_DIV = 8192;

  typedef enum logic {SWDT_SVC_IDLE, SWDT_SVC_ARMED} swdt_svc_e;

endpackage

// ### rtl/swdt_counter.sv
// Enable-gated period counter of the software watchdog timer
`timescale 1ns/1ps

module swdt_counter #(
  parameter int CNT_W = swdt_pkg::CNT_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic run,
  input wire logic restart,
  input wire logic [CNT_W-1:0] last,
  // Status
  output logic tick,
  output logic [CNT_W-1:0] count
);

  // ----------------------------------------------------------------
  // Count
  // ----------------------------------------------------------------
  // Comparing for equality with the terminal value keeps one adder;
  // a period shortened below the present count only ends at wrap,
  // which is why the new period waits for a service restart.
  assign tick = run && (count == last);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (restart) begin
      count <= '0;
    end else if (tick) begin
      count <= '0;
    end else if (run) begin
      count <= count + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  idle_hold_a: assert property (@(posedge clk) disable iff (rst)
    !run && !restart |=> $stable(count))
    else $error("watchdog count moved while disabled");

  restart_zero_a: assert property (@(posedge clk) disable iff (rst)
    restart |=> count == '0)
    else $error("service sequence did not restart count");

endmodule

// ### rtl/swdt_top.sv
// Software watchdog timer with register port, interrupt and bus terminate
`timescale 1ns/1ps

module swdt_top #(
  parameter int CNT_W = swdt_pkg::CNT_W,
  parameter int unsigned PERIOD_SHORT = swdt_pkg::PERIOD_SHORT,
  parameter int unsigned PRESCALE_DIV = swdt_pkg::PRESCALE_DIV
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,

  // Register port
  input wire logic [swdt_pkg::ADDR_W-1:0] addr,
  input wire logic [swdt_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [swdt_pkg::DATA_W-1:0] rdata,

  // Interrupt to the core
  input wire logic [swdt_pkg::LEVEL_W-1:0] irq_level_in,
  output logic irq_req,
  output logic [swdt_pkg::LEVEL_W-1:0] irq_level,

  // Interrupt acknowledge cycle
  input wire logic iack,
  output logic ack_valid,
  output logic [swdt_pkg::DATA_W-1:0] ack_vector,

  // Bus recovery and system reset
  output logic bus_terminate,
  output logic soft_reset,
  output logic reset_cause_set
);

  // ----------------------------------------------------------------
  // Period decode
  // ----------------------------------------------------------------
  // Each step of the period field is a factor of four; prescale
  // multiplies the whole period, so one counter covers all eight.
  function automatic logic [CNT_W-1:0] period_last(
    input logic prescale,
    input logic [1:0] field
  );
    logic [CNT_W:0] span;
    logic [CNT_W:0] less;
    span = (CNT_W+1)'(PERIOD_SHORT) << {field, 1'b0};
    if (prescale) begin
      span = span * (CNT_W+1)'(PRESCALE_DIV);
    end
    less = span - (CNT_W+1)'(1);
    return less[CNT_W-1:0];
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [swdt_pkg::DATA_W-1:0] ctrl;
  logic [swdt_pkg::DATA_W-1:0] vector;
  logic term_flag;
  logic pending;
  logic active_prescale;
  logic [1:0] active_field;
  swdt_pkg::swdt_svc_e svc_state;
  swdt_pkg::swdt_svc_e next_svc_state;

  logic tick;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] last;

  logic ctrl_wr;
  logic ctrl_wr_ok;
  logic vector_wr;
  logic svc_wr;
  logic svc_done;
  logic irq_evt;
  logic reset_evt;
  logic term_evt;
  logic ack_evt;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign ctrl_wr = wr && (addr == swdt_pkg::CTRL_ADDR);
  assign ctrl_wr_ok = ctrl_wr && !pending;
  assign vector_wr = wr && (addr == swdt_pkg::VECTOR_ADDR);
  assign svc_wr = wr && (addr == swdt_pkg::SERVICE_ADDR);

  assign svc_done = svc_wr && (svc_state == swdt_pkg::SWDT_SVC_ARMED)
    && (wdata == swdt_pkg::SERVICE_KEY2);

  assign irq_evt = tick && !ctrl[swdt_pkg::ACTION_BIT] && !pending;
  assign reset_evt = tick && ctrl[swdt_pkg::ACTION_BIT];
  assign term_evt = tick && !ctrl[swdt_pkg::ACTION_BIT] && pending
    && ctrl[swdt_pkg::TERM_EN_BIT];
  assign ack_evt = iack && pending;

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= swdt_pkg::CTRL_RESET;
    end else if (ctrl_wr_ok) begin
      ctrl <= wdata;
    end
  end

  // A clear needs no interrupt pending and this timeout needs one, so they never meet; the timeout is ordered first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      term_flag <= 1'b0;
    end else if (term_evt) begin
      term_flag <= 1'b1;
    end else if (ctrl_wr_ok && wdata[swdt_pkg::TERM_FLAG_BIT]) begin
      term_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Vector register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vector <= swdt_pkg::VECTOR_RESET;
    end else if (vector_wr) begin
      vector <= wdata;
    end
  end

  // ----------------------------------------------------------------
  // Service sequence
  // ----------------------------------------------------------------
  // No byte is stored: only the arming state is kept, so any
  // traffic may fall between the two keys.
  always_comb begin
    next_svc_state = svc_state;
    if (svc_wr) begin
      unique case (svc_state)
        swdt_pkg::SWDT_SVC_IDLE: begin
          if (wdata == swdt_pkg::SERVICE_KEY1) begin
            next_svc_state = swdt_pkg::SWDT_SVC_ARMED;
          end
        end
        swdt_pkg::SWDT_SVC_ARMED: begin
          if (wdata == swdt_pkg::SERVICE_KEY2) begin
            next_svc_state = swdt_pkg::SWDT_SVC_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      svc_state <= swdt_pkg::SWDT_SVC_IDLE;
    end else begin
      svc_state <= next_svc_state;
    end
  end

  // ----------------------------------------------------------------
  // Active period
  // ----------------------------------------------------------------
  // Period bits may change whenever no interrupt is pending; the counter only sees
  // them once software completes a service, avoiding a compare
  // against a half-written period.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      active_prescale <= 1'b0;
      active_field <= swdt_pkg::PERIOD_RESET;
    end else if (svc_done) begin
      active_prescale <= ctrl[swdt_pkg::PRESCALE_BIT];
      active_field <= ctrl[swdt_pkg::PERIOD_HI:swdt_pkg::PERIOD_LO];
    end
  end

  assign last = period_last(active_prescale, active_field);

  swdt_counter #(
    .CNT_W(CNT_W)
  ) swdt_counter_inst (
    .clk(clk),
    .rst(rst),
    .run(ctrl[swdt_pkg::ENABLE_BIT]),
    .restart(svc_done),
    .last(last),
    .tick(tick),
    .count(count)
  );

  // ----------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------
  // A timeout while pending takes the terminate path, so set and
  // acknowledge never meet here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pending <= 1'b0;
    end else if (irq_evt) begin
      pending <= 1'b1;
    end else if (ack_evt) begin
      pending <= 1'b0;
    end
  end

  assign irq_req = pending;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_level <= '0;
    end else if (irq_evt) begin
      irq_level <= irq_level_in;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_valid <= 1'b0;
      ack_vector <= '0;
    end else begin
      ack_valid <= ack_evt;
      if (ack_evt) begin
        ack_vector <= vector;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus terminate and soft reset
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_terminate <= 1'b0;
    end else begin
      bus_terminate <= term_evt;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      soft_reset <= 1'b0;
      reset_cause_set <= 1'b0;
    end else begin
      soft_reset <= reset_evt;
      reset_cause_set <= reset_evt;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Vector and service are write-only and read as zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else if (rd && (addr == swdt_pkg::CTRL_ADDR)) begin
      rdata <= {ctrl[7:2], term_flag, 1'b0};
    end else begin
      rdata <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  localparam int ACK_MIN = 1;
  localparam int ACK_MAX = 1;

  ctrl_write_block_a: assert property (@(posedge clk) disable iff (rst)
    ctrl_wr && pending |=> $stable(ctrl))
    else $error("control changed while interrupt pending");

  tick_at_period_a: assert property (@(posedge clk) disable iff (rst)
    tick |-> count == last && ctrl[swdt_pkg::ENABLE_BIT] ##1 count == '0)
    else $error("timeout away from selected period");

  irq_raise_a: assert property (@(posedge clk) disable iff (rst)
    irq_evt |=> irq_req && irq_level == $past(irq_level_in))
    else $error("interrupt not raised at timeout");

  soft_reset_pulse_a: assert property (@(posedge clk) disable iff (rst)
    reset_evt |=> soft_reset && reset_cause_set ##1 !soft_reset)
    else $error("soft reset not pulsed at timeout");

  terminate_second_a: assert property (@(posedge clk) disable iff (rst)
    tick && pending && ctrl[swdt_pkg::TERM_EN_BIT]
    && !ctrl[swdt_pkg::ACTION_BIT] |=> bus_terminate && term_flag)
    else $error("transfer acknowledge missing after second period");

  flag_clear_a: assert property (@(posedge clk) disable iff (rst)
    ctrl_wr_ok && wdata[swdt_pkg::TERM_FLAG_BIT] && !term_evt
    |=> !term_flag)
    else $error("terminate flag not cleared by write of one");

  flag_sticky_a: assert property (@(posedge clk) disable iff (rst)
    term_flag && !ctrl_wr_ok |=> term_flag)
    else $error("terminate flag dropped on its own");

  ack_vector_a: assert property (@(posedge clk) disable iff (rst)
    ack_evt |-> ##[ACK_MIN:ACK_MAX] ack_valid
    && ack_vector == $past(vector))
    else $error("vector not returned on acknowledge");

  service_no_clear_a: assert property (@(posedge clk) disable iff (rst)
    pending && svc_wr && !iack |=> irq_req)
    else $error("service write negated interrupt");

  period_latch_a: assert property (@(posedge clk) disable iff (rst)
    !svc_done |=> $stable(active_field) && $stable(active_prescale))
    else $error("period changed without service");

  bad_byte_a: assert property (@(posedge clk) disable iff (rst)
    svc_wr && wdata != swdt_pkg::SERVICE_KEY1
    && wdata != swdt_pkg::SERVICE_KEY2 |=> $stable(svc_state))
    else $error("unexpected service byte moved sequence");

  irq_hold_a: assert property (@(posedge clk) disable iff (rst)
    irq_req && !iack |=> irq_req)
    else $error("interrupt request dropped before acknowledge");

  ack_clear_a: assert property (@(posedge clk) disable iff (rst)
    irq_req && iack |=> !irq_req)
    else $error("interrupt request held after acknowledge");

  disabled_quiet_a: assert property (@(posedge clk) disable iff (rst)
    !ctrl[swdt_pkg::ENABLE_BIT] |=> !soft_reset && !bus_terminate)
    else $error("timeout action while watchdog disabled");

  service_cover_c: cover property (@(posedge clk) disable iff (rst)
    svc_done);

  irq_ack_cover_c: cover property (@(posedge clk) disable iff (rst)
    irq_evt ##[1:1000] ack_evt);

  terminate_cover_c: cover property (@(posedge clk) disable iff (rst)
    term_evt);

  reset_cover_c: cover property (@(posedge clk) disable iff (rst)
    reset_evt);

endmodule

// ### verification/swdt_cpu_model.sv
// Core and bus model issuing register accesses and acknowledge cycles
`timescale 1ns/1ps

module swdt_cpu_model (
  // Clock
  input wire logic clk,
  // Register port
  output logic [swdt_pkg::ADDR_W-1:0] addr,
  output logic [swdt_pkg::DATA_W-1:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [swdt_pkg::DATA_W-1:0] rdata,
  // Interrupt acknowledge
  output logic iack
);
  initial begin
    addr = 2'h3;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    iack = 1'b0;
  end

  // Released lines flip so a stale address or byte never looks valid
  task automatic bus_idle();
    addr <= ~addr;
    wdata <= ~wdata;
  endtask

  task automatic write(input logic [swdt_pkg::ADDR_W-1:0] a,
                       input logic [swdt_pkg::DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    bus_idle();
  endtask

  task automatic read(input logic [swdt_pkg::ADDR_W-1:0] a,
                      output logic [swdt_pkg::DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    bus_idle();
    #1 d = rdata;
  endtask

  // Keys go out in order, back to back with no traffic between them
  task automatic service();
    write(swdt_pkg::SERVICE_ADDR, swdt_pkg::SERVICE_KEY1);
    write(swdt_pkg::SERVICE_ADDR, swdt_pkg::SERVICE_KEY2);
  endtask

  task automatic ack_cycle();
    @(posedge clk);
    iack <= 1'b1;
    @(posedge clk);
    iack <= 1'b0;
    #1;
  endtask
endmodule

// ### verification/swdt_top_tb.sv
// Self-checking testbench of the software watchdog timer
`timescale 1ns/1ps

module swdt_top_tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int PS = 8;
  localparam int DIV = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [swdt_pkg::ADDR_W-1:0] addr;
  logic [swdt_pkg::DATA_W-1:0] wdata;
  logic wr;
  logic rd;
  logic iack;
  logic [swdt_pkg::DATA_W-1:0] rdata;
  logic [2:0] irq_level_in = 3'h0;
  logic irq_req;
  logic [2:0] irq_level;
  logic ack_valid;
  logic [7:0] ack_vector;
  logic bus_terminate;
  logic soft_reset;
  logic reset_cause_set;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  int mark = 0;
  int n;
  logic [7:0] vec = 8'h0f;

  always #20 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  swdt_top #(.CNT_W(28), .PERIOD_SHORT(PS), .PRESCALE_DIV(DIV)) swdt_top_inst (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .irq_level_in(irq_level_in), .irq_req(irq_req), .irq_level(irq_level), .iack(iack),
    .ack_valid(ack_valid), .ack_vector(ack_vector), .bus_terminate(bus_terminate),
    .soft_reset(soft_reset), .reset_cause_set(reset_cause_set));

  swdt_cpu_model swdt_cpu_model_inst (
    .clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .iack(iack));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    swdt_cpu_model_inst.read(a, d);
    check(what, d, exp);
  endtask

  // Cycle counts are taken from the edge that accepted this write
  task automatic wr_ctrl(input logic [7:0] d);
    swdt_cpu_model_inst.write(swdt_pkg::CTRL_ADDR, d);
    #1 mark = cyc;
  endtask

  // Period is latched with the count cleared while disabled
  task automatic arm(input logic [7:0] c);
    wr_ctrl(c & 8'h7f);
    swdt_cpu_model_inst.service();
    wr_ctrl(c);
  endtask

  function automatic logic hit(input int sel);
    return sel == 0 ? irq_req : (sel == 1 ? bus_terminate : soft_reset);
  endfunction

  task automatic wait_rise(input int sel, output int cnt);
    int k;
    k = 0;
    while (hit(sel) !== 1'b1 && k < 5000) begin
      @(posedge clk);
      #1 k++;
    end
    cnt = cyc - mark;
  endtask

  task automatic finish_irq(input int expn);
    wait_rise(0, n);
    check("timeout cycles", n, expn);
    check("irq level", irq_level, irq_level_in);
    swdt_cpu_model_inst.ack_cycle();
    check("ack valid", ack_valid, 1'b1);
    check("ack vector", ack_vector, vec);
    check("irq after ack", irq_req, 1'b0);
    wr_ctrl(8'h00);
  endtask

  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd_chk(swdt_pkg::CTRL_ADDR, 8'h00, "ctrl reset");
    rd_chk(swdt_pkg::VECTOR_ADDR, 8'h00, "vector read");
    rd_chk(swdt_pkg::SERVICE_ADDR, 8'h00, "service read");
    rd_chk(2'h3, 8'h00, "unmapped read");
    repeat (20) @(posedge clk);
    check("idle irq", irq_req, 1'b0);
    wr_ctrl(8'h80);
    finish_irq(PS);
    $display("test reset done");

    swdt_cpu_model_inst.write(swdt_pkg::VECTOR_ADDR, 8'h3c);
    vec = 8'h3c;
    wr_ctrl(8'h18);
    swdt_cpu_model_inst.service();
    wr_ctrl(8'h80);
    finish_irq(PS * 64);
    for (int p = 0; p < 2; p++) begin
      for (int f = 0; f < 4; f++) begin
        @(posedge clk);
        irq_level_in <= 3'(p * 4 + f);
        arm(8'(8'h80 | (p << 5) | (f << 3)));
        finish_irq(PS * (1 << (2 * f)) * (p == 1 ? DIV : 1));
      end
    end
    $display("test periods done");

    arm(8'h88);
    swdt_cpu_model_inst.write(swdt_pkg::SERVICE_ADDR, 8'haa);
    swdt_cpu_model_inst.write(swdt_pkg::SERVICE_ADDR, 8'h12);
    finish_irq(PS * 4);
    arm(8'h88);
    swdt_cpu_model_inst.write(swdt_pkg::SERVICE_ADDR, 8'h55);
    rd_chk(swdt_pkg::CTRL_ADDR, 8'h88, "ctrl between keys");
    swdt_cpu_model_inst.write(swdt_pkg::SERVICE_ADDR, 8'h12);
    swdt_cpu_model_inst.write(swdt_pkg::SERVICE_ADDR, 8'haa);
    #1 mark = cyc;
    finish_irq(PS * 4);
    $display("test service done");

    arm(8'h8c);
    wait_rise(0, n);
    #0 mark = cyc;
    swdt_cpu_model_inst.write(swdt_pkg::CTRL_ADDR, 8'h00);
    wait_rise(1, n);
    check("terminate cycles", n, PS * 4);
    rd_chk(swdt_pkg::CTRL_ADDR, 8'h8e, "ctrl pending");
    swdt_cpu_model_inst.service();
    check("irq after service", irq_req, 1'b1);
    swdt_cpu_model_inst.ack_cycle();
    wr_ctrl(8'h06);
    rd_chk(swdt_pkg::CTRL_ADDR, 8'h04, "flag cleared");
    $display("test terminate done");

    arm(8'hc0);
    wait_rise(2, n);
    check("reset cycles", n, PS);
    check("reset cause", reset_cause_set, 1'b1);
    check("no irq on reset", irq_req, 1'b0);
    wr_ctrl(8'h00);
    $display("test reset action done");
    test_done();
  end

  // Whole run needs about 5000 cycles
  initial begin
    #(20000 * 40);
    bad_count++;
    $display("watchdog expired");
    test_done();
  end
endmodule
